// *** mds_pkg.sv ***
// constants, field layouts and state types for the serial control port
// assumes both ends share one system clock rate of 125 MHz
//
// Overview of operation
// - half-duplex byte frames, driver is secondary only
// - primary alone generates the transfer clock
// - select high forces idle, output released
// - select falling edge starts a new frame
// - primary holds select low whole frame
// - select high aborts transfer at once
// - secondary captures input on falling clock edge
// - secondary shifts output on rising edge, open-drain
// - open-drain service request, independent of transfers
// - output enable high releases all fifteen outputs
// - bias level, on bit, latched/live status
// - offset level, on bit, latched/live status
// - primary lowers offset code at shutdown
// - primary disables reset converter by write
// - primary configures driver after power up
// - select pulses shorter than filter width ignored by write commit gate
// - no minimum clock rate, state held
package mds_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         CLK_NS     = 8;
    localparam int         FILTER_NS  = 150;
    localparam int         FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int         HALF_NS    = 1000;
    localparam int         HALF_CYC   = (HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] FILT_LAST  = 5'(FILTER_CYC - 1);
    localparam logic [6:0] HALF_LAST  = 7'(HALF_CYC - 1);
    // ----------------------------------------------------------------
    // frame layout: command byte (read bit, address) then data byte
    // ----------------------------------------------------------------
    localparam int         NUM_OUT   = 15;
    localparam int         CTL_W     = 5;
    localparam int         ON_BIT    = 4;
    localparam int         FRM_RD    = 14;
    localparam logic [4:0] CNT_DATA  = 5'h08;
    localparam logic [4:0] CNT_END   = 5'h10;
    localparam logic [4:0] CNT_ONE   = 5'h01;
    // ----------------------------------------------------------------
    // device register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] RA_BIAS   = 7'h00;
    localparam logic [6:0] RA_OFFSET = 7'h01;
    localparam logic [6:0] RA_STATUS = 7'h02;
    localparam logic [6:0] RA_MISC   = 7'h03;
    localparam logic [4:0] CTL_RST   = 5'h00;
    localparam int         MISC_RCONV = 0;
    // status byte: live bits low nibble, latched copies high nibble
    localparam int         ST_LIVE   = 0;
    localparam int         ST_LATCH  = 4;
    localparam int         NUM_COND  = 4;
    // readback vector seen by the link side
    localparam int         RV_BIAS   = 0;
    localparam int         RV_OFF    = 5;
    localparam int         RV_ST     = 10;
    localparam int         RV_MISC   = 18;
    localparam int         RV_W      = 19;
    // ----------------------------------------------------------------
    // primary command port
    // ----------------------------------------------------------------
    localparam logic [1:0] HA_XFER   = 2'h0;
    localparam logic [1:0] HA_STATUS = 2'h1;
    localparam logic [1:0] HA_RXDATA = 2'h2;
    localparam logic [1:0] HA_ABORT  = 2'h3;
    localparam int         X_RD_BIT  = 15;
    localparam int         HS_BUSY   = 0;
    localparam int         HS_IRQ    = 1;

    typedef enum logic [1:0] {
        MDS_IDLE = 2'b00,
        MDS_HIGH = 2'b01,
        MDS_LOW  = 2'b10,
        MDS_GAP  = 2'b11
    } mds_hstate_t;
endpackage

// *** mds_link_if.sv ***
// link between display controller (primary) and driver (secondary)
// assumes external pull-ups on serial data out and service request
`timescale 1ns/1ps
interface mds_link_if;
    logic sck;
    logic selN;
    logic sdi;
    logic sdoOut;
    logic sdoOeN;
    logic irqOut;
    logic irqOeN;
    logic serialOut;
    logic irqN;

    // ----------------------------------------------------------------
    // open-drain wire levels
    // ----------------------------------------------------------------
    assign serialOut = sdoOeN ? 1'b1 : sdoOut;
    assign irqN      = irqOeN ? 1'b1 : irqOut;

    modport secondary (
        input  sck,
        input  selN,
        input  sdi,
        output sdoOut,
        output sdoOeN,
        output irqOut,
        output irqOeN
    );
    modport primary (
        output sck,
        output selN,
        output sdi,
        input  serialOut,
        input  irqN
    );
endinterface

// *** mds_secondary.sv ***
// driver end of the serial control port with regulator control bits
// assumes link clock from the primary, idle high; clk is 125 MHz
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module mds_secondary
    import mds_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    mds_link_if.secondary         link,
    input  wire logic             biasUvRaw,
    input  wire logic             biasClRaw,
    input  wire logic             offUvRaw,
    input  wire logic             offClRaw,
    input  wire logic             serviceReq,
    input  wire logic             outEnN,
    input  wire logic [NUM_OUT-1:0] pulseCmd,
    output logic [3:0]            biasLevel,
    output logic                  biasOn,
    output logic [3:0]            offsetLevel,
    output logic                  offsetOn,
    output logic                  resetConvOff,
    output logic [NUM_OUT-1:0]    pulseOut,
    output logic [NUM_OUT-1:0]    pulseOutOeN
);
    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0]  cnt;
        logic [14:0] shreg;
        logic        isRead;
        logic [7:0]  rdByte;
    } mds_xfer_t;

    typedef struct packed {
        logic          commitTgl;
        logic [6:0]    wAddr;
        logic [7:0]    wData;
        logic [RV_W-1:0] rdS1;
        logic [RV_W-1:0] rdS2;
    } mds_lnk_t;

    typedef struct packed {
        logic                tS1;
        logic                tS2;
        logic                tS3;
        logic                selS1;
        logic                selS2;
        logic                selFilt;
        logic [4:0]          fCnt;
        logic [NUM_COND-1:0] liveS1;
        logic [NUM_COND-1:0] liveS2;
        logic [NUM_COND-1:0] latched;
        logic [CTL_W-1:0]    bias;
        logic [CTL_W-1:0]    off;
        logic                rconvOff;
        logic                oeS1;
        logic                oeS2;
        logic [NUM_OUT-1:0]  pOut;
        logic [NUM_OUT-1:0]  pOeN;
        logic                irqOeN;
    } mds_sys_t;

    mds_xfer_t x;
    mds_xfer_t next_x;
    mds_lnk_t  l;
    mds_lnk_t  next_l;
    mds_sys_t  s;
    mds_sys_t  next_s;
    logic      sdoOeN;
    logic      next_sdoOeN;
    logic      linkRstN;
    logic [RV_W-1:0] rdVec;
    logic [4:0]      bitIdx;

    // ----------------------------------------------------------------
    // readback decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] regRead(input logic [6:0] a, input logic [RV_W-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            RA_BIAS:   r = {3'h0, v[RV_BIAS +: CTL_W]};
            RA_OFFSET: r = {3'h0, v[RV_OFF +: CTL_W]};
            RA_STATUS: r = v[RV_ST +: 8];
            RA_MISC:   r = {7'h00, v[RV_MISC]};
            default:   r = 8'h00;
        endcase
        return r;
    endfunction

    assign linkRstN = rstn & ~link.selN;

    assign rdVec = {s.rconvOff, s.latched, s.liveS2, s.off, s.bias};

    // ----------------------------------------------------------------
    // link side, falling edge capture
    // ----------------------------------------------------------------
    always_comb
    begin
        next_x = x;
        next_l = l;
        // per-bit level sync, each bit is an independent level
        next_l.rdS1 = rdVec;
        next_l.rdS2 = l.rdS1;
        if (x.cnt != CNT_END)
        begin
            next_x.cnt   = x.cnt + CNT_ONE;
            next_x.shreg = {x.shreg[13:0], link.sdi};
        end
        if (x.cnt == CNT_DATA - CNT_ONE)
        begin
            next_x.isRead = x.shreg[6];
            next_x.rdByte = regRead({x.shreg[5:0], link.sdi}, l.rdS2);
        end
        if (x.cnt == CNT_END - CNT_ONE && !x.shreg[FRM_RD])
        begin
            next_l.wAddr     = x.shreg[13:7];
            next_l.wData     = {x.shreg[6:0], link.sdi};
            next_l.commitTgl = ~l.commitTgl;
        end
    end

    always_ff @(negedge link.sck or negedge linkRstN)
    begin
        if (!linkRstN)
            x <= '0;
        else
            x <= next_x;
    end

    always_ff @(negedge link.sck or negedge rstn)
    begin
        if (!rstn)
            l <= '0;
        else
            l <= next_l;
    end

    // ----------------------------------------------------------------
    // link side, rising edge shift out
    // ----------------------------------------------------------------
    assign bitIdx = CNT_END - CNT_ONE - x.cnt;

    always_comb
    begin
        next_sdoOeN = 1'b1;
        if (x.isRead && x.cnt >= CNT_DATA && x.cnt < CNT_END)
            next_sdoOeN = x.rdByte[bitIdx[2:0]];
    end

    always_ff @(posedge link.sck or negedge linkRstN)
    begin
        if (!linkRstN)
            sdoOeN <= 1'b1;
        else
            sdoOeN <= next_sdoOeN;
    end

    assign link.sdoOut = 1'b0;
    assign link.sdoOeN = sdoOeN;

    // ----------------------------------------------------------------
    // system side
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.tS1    = l.commitTgl;
        next_s.tS2    = s.tS1;
        next_s.tS3    = s.tS2;
        next_s.selS1  = link.selN;
        next_s.selS2  = s.selS1;
        next_s.liveS1 = {offClRaw, offUvRaw, biasClRaw, biasUvRaw};
        next_s.liveS2 = s.liveS1;
        next_s.oeS1   = outEnN;
        next_s.oeS2   = s.oeS1;
        if (s.selS2 != s.selFilt)
        begin
            next_s.fCnt = s.fCnt + 5'h01;
            if (s.fCnt == FILT_LAST)
            begin
                next_s.selFilt = s.selS2;
                next_s.fCnt    = 5'h00;
            end
        end
        else
            next_s.fCnt = 5'h00;
        next_s.latched = s.latched | s.liveS2;
        if (s.tS2 != s.tS3 && !s.selFilt)
        begin
            unique case (l.wAddr)
                RA_BIAS:   next_s.bias = l.wData[CTL_W-1:0];
                RA_OFFSET: next_s.off = l.wData[CTL_W-1:0];
                RA_STATUS: next_s.latched = (s.latched & ~l.wData[ST_LATCH +: NUM_COND]) | s.liveS2;
                RA_MISC:   next_s.rconvOff = l.wData[MISC_RCONV];
                default:   next_s.rconvOff = s.rconvOff;
            endcase
        end
        next_s.pOeN = {NUM_OUT{s.oeS2}};
        next_s.pOut = s.oeS2 ? '0 : pulseCmd;
        next_s.irqOeN = ~serviceReq;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s          <= '0;
            s.selS1    <= 1'b1;
            s.selS2    <= 1'b1;
            s.selFilt  <= 1'b1;
            s.bias     <= CTL_RST;
            s.off      <= CTL_RST;
            s.oeS1     <= 1'b1;
            s.oeS2     <= 1'b1;
            s.pOeN     <= '1;
            s.irqOeN   <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign link.irqOut  = 1'b0;
    assign link.irqOeN  = s.irqOeN;
    assign biasLevel    = s.bias[3:0];
    assign biasOn       = s.bias[ON_BIT];
    assign offsetLevel  = s.off[3:0];
    assign offsetOn     = s.off[ON_BIT];
    assign resetConvOff = s.rconvOff;
    assign pulseOut     = s.pOut;
    assign pulseOutOeN  = s.pOeN;
endmodule

// *** mds_primary.sv ***
// controller end: runs frames on command from a plain register port
// assumes clk 125 MHz; the link clock is divided down from it
`timescale 1ns/1ps
module mds_primary
    import mds_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    mds_link_if.primary      link,
    input  wire logic [1:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata
);
    typedef struct packed {
        mds_hstate_t st;
        logic [6:0]  div;
        logic [4:0]  bitCnt;
        logic [15:0] tx;
        logic [7:0]  rx;
        logic        sck;
        logic        selN;
        logic        sdi;
        logic        sdoS1;
        logic        sdoS2;
        logic        irqS1;
        logic        irqS2;
        logic [15:0] rdata;
    } mds_host_t;

    mds_host_t h;
    mds_host_t next_h;

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_h = h;
        next_h.sdoS1 = link.serialOut;
        next_h.sdoS2 = h.sdoS1;
        next_h.irqS1 = link.irqN;
        next_h.irqS2 = h.irqS1;
        next_h.rdata = 16'h0000;
        if (rd)
        begin
            unique case (addr)
                HA_STATUS:
                begin
                    next_h.rdata[HS_BUSY] = (h.st != MDS_IDLE);
                    next_h.rdata[HS_IRQ]  = ~h.irqS2;
                end
                HA_RXDATA: next_h.rdata = {8'h00, h.rx};
                default:   next_h.rdata = 16'h0000;
            endcase
        end
        if (wr && addr == HA_ABORT)
        begin
            next_h.st   = MDS_GAP;
            next_h.div  = 7'h00;
            next_h.selN = 1'b1;
            next_h.sck  = 1'b1;
        end
        else
        begin
            unique case (h.st)
                MDS_IDLE:
                begin
                    if (wr && addr == HA_XFER)
                    begin
                        next_h.tx     = wdata;
                        next_h.sdi    = wdata[X_RD_BIT];
                        next_h.selN   = 1'b0;
                        next_h.sck    = 1'b1;
                        next_h.bitCnt = 5'h00;
                        next_h.div    = 7'h00;
                        next_h.st     = MDS_HIGH;
                    end
                end
                MDS_HIGH:
                begin
                    next_h.div = h.div + 7'h01;
                    if (h.div == HALF_LAST)
                    begin
                        next_h.div = 7'h00;
                        if (h.bitCnt == CNT_END)
                        begin
                            next_h.selN = 1'b1;
                            next_h.st   = MDS_GAP;
                        end
                        else
                        begin
                            if (h.bitCnt >= CNT_DATA)
                                next_h.rx = {h.rx[6:0], h.sdoS2};
                            next_h.sck = 1'b0;
                            next_h.st  = MDS_LOW;
                        end
                    end
                end
                MDS_LOW:
                begin
                    next_h.div = h.div + 7'h01;
                    if (h.div == HALF_LAST)
                    begin
                        next_h.div    = 7'h00;
                        next_h.sck    = 1'b1;
                        next_h.bitCnt = h.bitCnt + CNT_ONE;
                        next_h.tx     = {h.tx[14:0], 1'b0};
                        next_h.sdi    = h.tx[14];
                        next_h.st     = MDS_HIGH;
                    end
                end
                MDS_GAP:
                begin
                    // select high stays above filter width
                    next_h.div = h.div + 7'h01;
                    if (h.div == HALF_LAST)
                    begin
                        next_h.div = 7'h00;
                        next_h.st  = MDS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            h       <= '0;
            h.st    <= MDS_IDLE;
            h.sck   <= 1'b1;
            h.selN  <= 1'b1;
            h.sdoS1 <= 1'b1;
            h.sdoS2 <= 1'b1;
            h.irqS1 <= 1'b1;
            h.irqS2 <= 1'b1;
        end
        else
            h <= next_h;
    end

    assign link.sck  = h.sck;
    assign link.selN = h.selN;
    assign link.sdi  = h.sdi;
    assign rdata     = h.rdata;
endmodule

// *** mds_link_properties.sv ***
// concurrent checks on the link between the two ends
// assumes one clk for both ends and the link signals as plain inputs
`timescale 1ns/1ps
module mds_link_properties
    import mds_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic selN,
    input wire logic sdi,
    input wire logic sdoOut,
    input wire logic sdoOeN,
    input wire logic irqOut,
    input wire logic irqOeN,
    input wire logic serialOut,
    input wire logic irqN
);
    logic [6:0] hold;
    logic [5:0] edges;
    logic [7:0] idleCnt;
    logic       sckQ;
    logic       rdBit;
    logic       seenFrame;
    logic [5:0] edgesNow;

    // edge count including a change seen at this very sample
    assign edgesNow = edges + {5'h00, sck != sckQ};

    // ----------------------------------------------------------------
    // helper counters
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold      <= 7'h00;
            edges     <= 6'h00;
            idleCnt   <= 8'h00;
            sckQ      <= 1'b1;
            rdBit     <= 1'b0;
            seenFrame <= 1'b0;
        end
        else
        begin
            sckQ    <= sck;
            hold    <= (sck != sckQ) ? 7'h00 : ((hold == 7'h7f) ? hold : hold + 7'h01);
            edges   <= selN ? 6'h00 : ((sck != sckQ) ? edges + 6'h01 : edges);
            idleCnt <= !selN ? 8'h00 : ((idleCnt == 8'hff) ? idleCnt : idleCnt + 8'h01);
            if (!selN && sck != sckQ && edges == 6'h00)
                rdBit <= sdi;
            if (!selN)
                seenFrame <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_SDO_IDLE_RELEASED: assert property (selN && $past(selN) |-> sdoOeN)
        else $error("data out driven while deselected");
    AST_FRAME_STARTS_HIGH: assert property ($fell(selN) |-> sck)
        else $error("frame began with clock low");
    AST_HALF_PERIOD: assert property (!selN && sck != sckQ && edges != 6'h00 |-> hold == HALF_LAST)
        else $error("clock phase length wrong");
    AST_SDO_LOW_ONLY: assert property (!sdoOeN |-> !sdoOut)
        else $error("data out drives high");
    AST_SDO_FALL_IN_HIGH: assert property (!selN && $fell(sdoOeN) |-> sck)
        else $error("data out changed in low clock phase");
    AST_NO_DRIVE_COMMAND: assert property (!selN && edgesNow < 6'h10 |-> sdoOeN)
        else $error("data out driven during command byte");
    AST_WRITE_NO_DRIVE: assert property (!selN && edges != 6'h00 && !rdBit |-> sdoOeN)
        else $error("data out driven during write frame");
    AST_SDO_DONE_RELEASED: assert property (!selN && edges == 6'h20 |-> sdoOeN)
        else $error("data out held after last bit");
    AST_IRQ_LOW_ONLY: assert property (!irqOeN |-> !irqOut)
        else $error("request line drives high");
    AST_FRAME_GAP: assert property ($fell(selN) && seenFrame |-> idleCnt >= {1'b0, HALF_LAST})
        else $error("select gap too short");

    cover property ($fell(sdoOeN));
    cover property ($rose(selN) && edges != 6'h00 && edges < 6'h20);
    cover property ($fell(irqN));
    cover property (!selN && !serialOut);
endmodule

// *** tb_top.sv ***
// self-checking bench: primary and secondary joined by the link
// assumes the primary register port and 125 MHz clk for both ends
`timescale 1ns/1ps
module tb_top
    import mds_pkg::*;
;
    localparam int LIMIT = 90000;
    logic                 clk;
    logic                 rstn;
    logic [1:0]           addr;
    logic [15:0]          wdata;
    logic                 wr;
    logic                 rd;
    logic [15:0]          rdata;
    logic                 biasUvRaw;
    logic                 biasClRaw;
    logic                 offUvRaw;
    logic                 offClRaw;
    logic                 serviceReq;
    logic                 outEnN;
    logic [NUM_OUT-1:0]   pulseCmd;
    logic [3:0]           biasLevel;
    logic [3:0]           offsetLevel;
    logic                 biasOn;
    logic                 offsetOn;
    logic                 resetConvOff;
    logic [NUM_OUT-1:0]   pulseOut;
    logic [NUM_OUT-1:0]   pulseOutOeN;
    logic [15:0]          val;
    logic [7:0]           d;
    logic [3:0]           cond;
    int                   num_errors;
    int                   check_count;
    int                   cycles;
    int                   cfg[4];
    int                   latched;

    mds_link_if link();
    mds_primary u_mds_primary (.clk(clk), .rstn(rstn), .link(link), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    mds_secondary u_mds_secondary (.clk(clk), .rstn(rstn), .link(link), .biasUvRaw(biasUvRaw),
        .biasClRaw(biasClRaw), .offUvRaw(offUvRaw), .offClRaw(offClRaw), .serviceReq(serviceReq),
        .outEnN(outEnN), .pulseCmd(pulseCmd), .biasLevel(biasLevel), .biasOn(biasOn),
        .offsetLevel(offsetLevel), .offsetOn(offsetOn), .resetConvOff(resetConvOff),
        .pulseOut(pulseOut), .pulseOutOeN(pulseOutOeN));
    mds_link_properties u_mds_link_properties (.clk(clk), .rstn(rstn), .sck(link.sck), .selN(link.selN),
        .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOeN(link.sdoOeN), .irqOut(link.irqOut),
        .irqOeN(link.irqOeN), .serialOut(link.serialOut), .irqN(link.irqN));

    // ----------------------------------------------------------------
    // clock, timeout, reporting
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            num_errors++;
            $display("unexpected at %0t: run too long", $time);
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // register port and frame tasks
    // ----------------------------------------------------------------
    task automatic regWrite(input logic [1:0] a, input logic [15:0] dat);
        @(posedge clk);
        addr  <= a;
        wdata <= dat;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic regRead(input logic [1:0] a, output logic [15:0] dat);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        dat = rdata;
    endtask

    task automatic waitIdle;
        val = 16'h0001;
        while (val[HS_BUSY] !== 1'b0)
            regRead(HA_STATUS, val);
    endtask

    task automatic frame(input logic rdf, input logic [6:0] a, input logic [7:0] dat);
        regWrite(HA_XFER, {rdf, a, dat});
        waitIdle();
    endtask

    task automatic readBack(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] got;
        frame(1'b1, a, 8'($urandom));
        regRead(HA_RXDATA, got);
        check(got, exp);
    endtask

    task automatic checkCfg;
        check({11'h0, biasOn, biasLevel}, 16'(cfg[0]));
        check({11'h0, offsetOn, offsetLevel}, 16'(cfg[1]));
        check({15'h0, resetConvOff}, 16'(cfg[3]));
    endtask

    function automatic logic [15:0] expStatus;
        return {8'h00, 4'(latched), offClRaw, offUvRaw, biasClRaw, biasUvRaw};
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        addr = 2'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        {offClRaw, offUvRaw, biasClRaw, biasUvRaw} = 4'h0;
        serviceReq = 1'b0;
        outEnN = 1'b1;
        pulseCmd = '0;
        void'($urandom(32'h05ff942d));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        checkCfg();
        check({1'b0, pulseOutOeN}, 16'h7fff);
        check({15'h0, link.irqN}, 16'h0001);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($urandom);
            frame(1'b0, 7'(i), d);
            if (i < 2)
                cfg[i] = d & 8'h1f;
            if (i == 3)
                cfg[3] = d & 8'h01;
            checkCfg();
        end
        for (int i = 0; i < 4; i++)
            readBack(7'(i), (i == 2) ? expStatus() : 16'(cfg[i]));
        $display("test config done");
        regWrite(HA_XFER, {1'b0, RA_OFFSET, 8'h1c});
        regWrite(HA_XFER, {1'b0, RA_OFFSET, 8'h13});
        waitIdle();
        cfg[1] = 'h1c;
        checkCfg();
        frame(1'b0, RA_OFFSET, 8'h13);
        cfg[1] = 'h13;
        checkCfg();
        $display("test refused done");
        for (int j = 0; j < 3; j++)
        begin
            regWrite(HA_XFER, {(j == 1), RA_BIAS, 8'(cfg[0] ^ 'h1f)});
            repeat ((j == 0) ? 600 : ((j == 1) ? 2500 : 3800)) @(posedge clk);
            regWrite(HA_ABORT, 16'h0000);
            waitIdle();
            checkCfg();
        end
        $display("test abort done");
        cond = 4'($urandom) | 4'h1;
        @(posedge clk);
        {offClRaw, offUvRaw, biasClRaw, biasUvRaw} <= cond;
        repeat (10) @(posedge clk);
        latched = cond;
        readBack(RA_STATUS, expStatus());
        @(posedge clk);
        {offClRaw, offUvRaw, biasClRaw, biasUvRaw} <= 4'h0;
        repeat (10) @(posedge clk);
        readBack(RA_STATUS, expStatus());
        frame(1'b0, RA_STATUS, 8'hf0);
        latched = 0;
        readBack(RA_STATUS, expStatus());
        $display("test status done");
        @(posedge clk);
        serviceReq <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check({15'h0, link.irqN}, 16'h0000);
        regRead(HA_STATUS, val);
        check({15'h0, val[HS_IRQ]}, 16'h0001);
        @(posedge clk);
        serviceReq <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check({15'h0, link.irqN}, 16'h0001);
        $display("test request done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            pulseCmd <= NUM_OUT'($urandom);
            outEnN <= 1'b0;
            repeat (8) @(posedge clk);
            @(negedge clk);
            check({1'b0, pulseOutOeN}, 16'h0000);
            check({1'b0, pulseOut}, {1'b0, pulseCmd});
            @(posedge clk);
            outEnN <= 1'b1;
            repeat (8) @(posedge clk);
            @(negedge clk);
            check({1'b0, pulseOutOeN}, 16'h7fff);
            check({1'b0, pulseOut}, 16'h0000);
        end
        $display("test outputs done");
        give_verdict();
    end
endmodule
